// >>> hdl/msc_status_counters.v
// Upper status words of the module status block: counters and fault words
`timescale 1ns/1ns
`default_nettype none
`include "msc_status_regs.vh"

module msc_status_counters (
  input wire clock,
  input wire sys_rst,
  // Port roles: high while the port acts as slave
  input wire port1Slave,
  input wire port2Slave,
  // Port 1 error events
  input wire port1ReplyErrStb,
  input wire [15:0] port1ReplyErrCode,
  input wire port1SlaveErrStb,
  input wire [15:0] port1SlaveErrIndex,
  // Port 2 error events
  input wire port2ReplyErrStb,
  input wire [15:0] port2ReplyErrCode,
  input wire port2SlaveErrStb,
  input wire [15:0] port2SlaveErrIndex,
  // Backplane block events
  input wire inImageSentStb,
  input wire outImageRecvStb,
  input wire outImageParsedStb,
  input wire priorityCmdStb,
  input wire cmdTriggerStb,
  input wire linkBlockErrStb,
  // Status block read port
  input wire readReq,
  input wire [15:0] readBlockId,
  input wire [5:0] readIndex,
  output reg readValid,
  output reg [15:0] readData,
  output reg readRefused,
  // Health flag: parsed count lags output count
  output reg parseLagging
);

  // ==========================================================
  // Counter bank
  // Index 0..7 map to words 21..28 in order
  localparam NCNT = 8;
  reg [15:0] cnt [0:NCNT-1];
  wire [NCNT-1:0] cntEvt;
  wire port2IsMaster;

  assign port2IsMaster = ~port2Slave;
  assign cntEvt[0] = port2Slave & port2ReplyErrStb;
  assign cntEvt[1] = port2IsMaster & port2SlaveErrStb;
  assign cntEvt[2] = inImageSentStb;
  assign cntEvt[3] = outImageRecvStb;
  // A parse can only follow a received block, so gate by it
  assign cntEvt[4] = outImageParsedStb & outImageRecvStb;
  assign cntEvt[5] = priorityCmdStb;
  assign cntEvt[6] = cmdTriggerStb;
  assign cntEvt[7] = linkBlockErrStb;

  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi = gi + 1) begin : gCnt
      always @(posedge clock) begin
        if (sys_rst) begin
          cnt[gi] <= `MSC_COUNT_RESET;
        end else if (cntEvt[gi]) begin
          // Natural 16-bit wrap from all ones to zero
          cnt[gi] <= cnt[gi] + `MSC_COUNT_ONE;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Fault word pairs, one per port
  wire [15:0] p1Present;
  wire [15:0] p1Previous;
  wire [15:0] p2Present;
  wire [15:0] p2Previous;

  msc_fault_pair uPort1Fault (
    .clock(clock),
    .sys_rst(sys_rst),
    .slaveRole(port1Slave),
    .replyErrStb(port1ReplyErrStb),
    .replyErrCode(port1ReplyErrCode),
    .slaveErrStb(port1SlaveErrStb),
    .slaveErrIndex(port1SlaveErrIndex),
    .presentFault(p1Present),
    .previousFault(p1Previous)
  );

  msc_fault_pair uPort2Fault (
    .clock(clock),
    .sys_rst(sys_rst),
    .slaveRole(port2Slave),
    .replyErrStb(port2ReplyErrStb),
    .replyErrCode(port2ReplyErrCode),
    .slaveErrStb(port2SlaveErrStb),
    .slaveErrIndex(port2SlaveErrIndex),
    .presentFault(p2Present),
    .previousFault(p2Previous)
  );

  // ==========================================================
  // Word decode, shared by read path
  function inBank;
    input [5:0] idx;
    begin
      inBank = (idx >= `MSC_FIRST_WORD) && (idx <= `MSC_LAST_WORD);
    end
  endfunction

  function validReq;
    input [15:0] id;
    input [5:0] idx;
    begin
      validReq = (id == `MSC_STATUS_BLOCK_ID) && (idx < `MSC_BLOCK_WORDS);
    end
  endfunction

  // Words below 21 belong to another bank and read as zero here
  reg [15:0] next_readData;
  wire [5:0] cntSel;

  assign cntSel = readIndex - `MSC_FIRST_WORD;

  always @* begin
    next_readData = 16'h0000;
    if (inBank(readIndex)) begin
      case (readIndex)
        `MSC_PORT1_PRESENT_FAULT: next_readData = p1Present;
        `MSC_PORT1_PREVIOUS_FAULT: next_readData = p1Previous;
        `MSC_PORT2_PRESENT_FAULT: next_readData = p2Present;
        `MSC_PORT2_PREVIOUS_FAULT: next_readData = p2Previous;
        default: next_readData = cnt[cntSel[2:0]];
      endcase
    end
  end

  // ==========================================================
  // Read port: one word per request, answer on the next edge
  // Reads never alter the bank: every word is read-only to the host
  always @(posedge clock) begin
    if (sys_rst) begin
      readValid <= 1'b0;
      readRefused <= 1'b0;
      readData <= 16'h0000;
    end else begin
      readValid <= readReq & validReq(readBlockId, readIndex);
      readRefused <= readReq & ~validReq(readBlockId, readIndex);
      if (readReq && validReq(readBlockId, readIndex)) begin
        readData <= next_readData;
      end else begin
        readData <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // Backplane health: parsed count should stay close to output count
  wire [15:0] parseGap;

  assign parseGap = cnt[3] - cnt[4];

  always @(posedge clock) begin
    if (sys_rst) begin
      parseLagging <= 1'b0;
    end else begin
      // Tolerance of one block covers a parse still in flight
      parseLagging <= (parseGap > `MSC_COUNT_ONE);
    end
  end

endmodule // msc_status_counters
`default_nettype wire

// >>> hdl/msc_status_regs.vh
// Constants for the module status counter bank: word indices, widths, reset values
`ifndef MSC_STATUS_REGS_VH
`define MSC_STATUS_REGS_VH

// ==========================================================
// Block layout
`define MSC_BLOCK_WORDS 6'h21
`define MSC_FIRST_WORD 6'h15
`define MSC_LAST_WORD 6'h20
`define MSC_WORD_W 16
`define MSC_IDX_W 6
`define MSC_STATUS_BLOCK_ID 16'h9250

// ==========================================================
// Word indices of the bank
`define MSC_PORT2_ERROR_REPLIES_SENT 6'h15
`define MSC_PORT2_ERROR_REPLIES_RECEIVED 6'h16
`define MSC_INPUT_IMAGE_BLOCK_COUNT 6'h17
`define MSC_OUTPUT_IMAGE_BLOCK_COUNT 6'h18
`define MSC_PARSED_BLOCK_COUNT 6'h19
`define MSC_PRIORITY_COMMAND_BLOCK_COUNT 6'h1a
`define MSC_COMMAND_TRIGGER_BLOCK_COUNT 6'h1b
`define MSC_LINK_BLOCK_ERROR_COUNT 6'h1c
`define MSC_PORT1_PRESENT_FAULT 6'h1d
`define MSC_PORT1_PREVIOUS_FAULT 6'h1e
`define MSC_PORT2_PRESENT_FAULT 6'h1f
`define MSC_PORT2_PREVIOUS_FAULT 6'h20

// ==========================================================
// Reset values
`define MSC_COUNT_RESET 16'h0000
`define MSC_FAULT_RESET 16'h0000
`define MSC_COUNT_ONE 16'h0001

`endif

// >>> hdl/msc_fault_pair.v
// Present/previous fault word pair for one serial port
`timescale 1ns/1ns
`default_nettype none
`include "msc_status_regs.vh"

module msc_fault_pair (
  input wire clock,
  input wire sys_rst,
  input wire slaveRole,
  input wire replyErrStb,
  input wire [15:0] replyErrCode,
  input wire slaveErrStb,
  input wire [15:0] slaveErrIndex,
  output reg [15:0] presentFault,
  output reg [15:0] previousFault
);

  // ==========================================================
  // Update selection
  // The role decides which event source is allowed to load the pair
  wire loadEvt;
  wire [15:0] loadVal;

  assign loadEvt = slaveRole ? replyErrStb : slaveErrStb;
  assign loadVal = slaveRole ? replyErrCode : slaveErrIndex;

  // ==========================================================
  // Shift present into previous on every error from the source the role selects
  always @(posedge clock) begin
    if (sys_rst) begin
      presentFault <= `MSC_FAULT_RESET;
      previousFault <= `MSC_FAULT_RESET;
    end else if (loadEvt) begin
      presentFault <= loadVal;
      previousFault <= presentFault;
    end
  end

endmodule // msc_fault_pair
`default_nettype wire

// >>> tb/msc_host_model.sv
// Host side model that requests status words from the counter bank
`timescale 1ns/1ns
`default_nettype none
module msc_host_model (
  input wire logic clock,
  output logic readReq,
  output logic [15:0] readBlockId,
  output logic [5:0] readIndex
);
  // ====
  // Requests
  initial begin
    readReq = 1'b0;
    readBlockId = 16'h0000;
    readIndex = 6'h00;
  end
  // Entered at a falling edge; request held across one sampling edge
  task rd(input logic [15:0] id, input logic [5:0] ix);
    readReq = 1'b1;
    readBlockId = id;
    readIndex = ix;
    @(negedge clock);
  endtask
  // Released qualifiers toggle so a stale value never stays steady
  task idle;
    readReq = 1'b0;
    readBlockId = ~readBlockId;
    readIndex = ~readIndex;
  endtask
endmodule // msc_host_model
`default_nettype wire

// >>> tb/msc_status_counters_properties.sv
// Checker for the read port of the status counter bank
`timescale 1ns/1ns
`default_nettype none
module msc_sc_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic readReq,
  input wire logic [15:0] readBlockId,
  input wire logic [5:0] readIndex,
  input wire logic inImageSentStb,
  input wire logic readValid,
  input wire logic [15:0] readData,
  input wire logic readRefused,
  input wire logic parseLagging
);
  // ====
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire ok = readBlockId == 16'h9250 && readIndex <= 6'h20;
  wire rd23 = readReq && ok && readIndex == 6'h17;
  a_read_taken: assert property (readReq && ok |=> readValid && !readRefused)
    else $error("read not answered");
  a_read_refused: assert property (readReq && !ok |=> readRefused && readData == 16'h0000)
    else $error("bad read not refused");
  a_no_request: assert property (!readReq |=> !readValid && !readRefused)
    else $error("answer without request");
  a_data_idle: assert property (!readValid |-> readData == 16'h0000)
    else $error("data without valid");
  a_low_words: assert property (readReq && ok && readIndex < 6'h15 |=> readData == 16'h0000)
    else $error("lower word not zero");
  a_one_answer: assert property (!(readValid && readRefused))
    else $error("valid and refused together");
  a_reset_quiet: assert property ($past(sys_rst) |-> !readValid && !readRefused && !parseLagging)
    else $error("outputs not clear after reset");
  a_count_step: assert property ((rd23 && inImageSentStb) ##1 rd23 |=> readData == $past(readData) + 16'h0001)
    else $error("input image count did not step");
  c_valid: cover property (readValid);
  c_refused: cover property (readRefused);
  c_lagging: cover property (parseLagging);
endmodule // msc_sc_props
bind msc_status_counters msc_sc_props msc_sc_props_inst (.*);
`default_nettype wire

// >>> tb/test_msc_status_counters.sv
// Self-checking bench for the status counter bank
`timescale 1ns/1ns
`default_nettype none
module test_msc_status_counters;
  logic clock, sys_rst, port1Slave, port2Slave, port1ReplyErrStb, port1SlaveErrStb;
  logic port2ReplyErrStb, port2SlaveErrStb, inImageSentStb, outImageRecvStb;
  logic outImageParsedStb, priorityCmdStb, cmdTriggerStb, linkBlockErrStb;
  logic [15:0] port1ReplyErrCode, port1SlaveErrIndex, port2ReplyErrCode, port2SlaveErrIndex;
  logic [15:0] readBlockId, readData, m [0:63];
  logic readReq, readValid, readRefused, parseLagging;
  logic [5:0] readIndex;
  logic [16:0] q [$];
  logic [31:0] x = 32'h0000_f80b;
  int errCount = 0, comparisons = 0;
  msc_status_counters msc_status_counters_inst (.*);
  msc_host_model msc_host_model_inst (.*);
  // ====
  // Helpers
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  function logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task reportAndStop;
    if (errCount == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One cycle of events and an optional read; the model sees events after the read
  task step(input logic [31:0] r);
    logic [15:0] id;
    id = r[13] ? r[31:16] : 16'h9250;
    {port1Slave, port2Slave, port1ReplyErrStb, port1SlaveErrStb} = r[5:2];
    {port2ReplyErrStb, port2SlaveErrStb} = r[1:0];
    {cmdTriggerStb, linkBlockErrStb} = r[7:6];
    {inImageSentStb, outImageRecvStb, outImageParsedStb, priorityCmdStb} = r[11:8];
    port1ReplyErrCode = r[31:16];
    port1SlaveErrIndex = ~r[31:16];
    port2ReplyErrCode = r[15:0];
    port2SlaveErrIndex = ~r[15:0];
    if (r[12]) q.push_back(id == 16'h9250 && r[21:16] <= 6'h20 ? {1'b0, m[r[21:16]]} : 17'h1_0000);
    if (r[4] & r[1]) m[21]++;
    if (!r[4] & r[0]) m[22]++;
    m[23] += r[11];
    m[24] += r[10];
    m[25] += r[10] & r[9];
    m[26] += r[8];
    m[27] += r[7];
    m[28] += r[6];
    if (r[5] ? r[3] : r[2]) {m[30], m[29]} = {m[29], r[5] ? r[31:16] : ~r[31:16]};
    if (r[4] ? r[1] : r[0]) {m[32], m[31]} = {m[31], r[4] ? r[15:0] : ~r[15:0]};
    if (r[12]) msc_host_model_inst.rd(id, r[21:16]);
    else begin
      msc_host_model_inst.idle;
      @(negedge clock);
    end
  endtask
  // Answers are looked at on the falling edge, where the registered outputs have settled
  always @(negedge clock) if (readValid === 1'b1 || readRefused === 1'b1) check({readRefused, readData}, q.pop_front());
  initial begin
    #1600000;
    errCount++;
    reportAndStop;
  end
  // ====
  // Scenarios
  initial begin
    foreach (m[j]) m[j] = 16'h0000;
    sys_rst = 1'b1;
    repeat (10) step(32'h0000_0000);
    sys_rst = 1'b0;
    for (int i = 0; i < 34; i++) step({10'h000, i[5:0], 16'h1000});
    step(32'h0017_1800);
    step(32'h0017_1000);
    repeat (65536) step(32'hffff_efff);
    check({16'h0000, parseLagging}, {16'h0000, m[24] - m[25] > 16'h0001});
    repeat (3000) begin
      x = xs(x);
      step(x);
    end
    for (int i = 0; i < 34; i++) step({10'h000, i[5:0], 16'h1000});
    repeat (3) step(32'h0000_0000);
    check({16'h0000, parseLagging}, {16'h0000, m[24] - m[25] > 16'h0001});
    // Every queued read must have been answered by now
    check(17'(q.size()), 17'h0_0000);
    reportAndStop;
  end
endmodule // test_msc_status_counters
`default_nettype wire
